// ---- verilog/dcec_pkg.sv ----
`default_nettype none
package dcec_pkg;
   localparam int DCEC_AW = 5;
   localparam int DCEC_DW = 32;
   localparam int DCEC_NSRC = 16;
   localparam int DCEC_SELW = 4;
   localparam int DCEC_STW = 4;

   // register byte offsets
   localparam logic [DCEC_AW-1:0] DCEC_CTRL_OFF = 5'h00;
   localparam logic [DCEC_AW-1:0] DCEC_SRC_OFF = 5'h04;
   localparam logic [DCEC_AW-1:0] DCEC_STAT_OFF = 5'h08;
   localparam logic [DCEC_AW-1:0] DCEC_MASK_OFF = 5'h0c;
   localparam logic [DCEC_AW-1:0] DCEC_STATE_OFF = 5'h10;

   // channel_control_register fields
   localparam int DCEC_CH1_MASTER_BIT = 7;
   localparam int DCEC_CH1_XFER_BIT = 6;
   localparam int DCEC_CH0_MASTER_BIT = 5;
   localparam int DCEC_CH0_XFER_BIT = 4;
   localparam int DCEC_CH1_END_IE_BIT = 2;
   localparam int DCEC_CH0_BURST_BIT = 8;

   // source select fields
   localparam int DCEC_CH0_SEL_LSB = 0;
   localparam int DCEC_CH1_SEL_LSB = 4;

   // status / mask bits
   localparam int DCEC_ST_CH1_END = 0;
   localparam int DCEC_ST_CH0_BREAK = 1;
   localparam int DCEC_ST_CH0_DONE = 2;
   localparam int DCEC_ST_CH1_DONE = 3;

   // state register bits
   localparam int DCEC_SS_CH0_RUN = 0;
   localparam int DCEC_SS_CH1_RUN = 1;
   localparam int DCEC_SS_CH0_HELD = 2;
   localparam int DCEC_SS_CH1_END_REQ = 3;

   localparam logic [DCEC_SELW-1:0] DCEC_SEL_RST = 4'h0;
   localparam logic [DCEC_STW-1:0] DCEC_STAT_RST = 4'h0;
   localparam logic [DCEC_STW-1:0] DCEC_MASK_RST = 4'h0;

   typedef struct packed {
      logic ch0Burst;
      logic ch1Master;
      logic ch1Xfer;
      logic ch0Master;
      logic ch0Xfer;
      logic ch1EndIe;
   } dcec_ctrl_t;

   localparam dcec_ctrl_t DCEC_CTRL_RST = '0;

   // completion and progress from the transfer engine
   typedef struct packed {
      logic ch0Done;
      logic ch1Done;
      logic ch0BurstBusy;
   } dcec_eng_t;
endpackage
`default_nettype wire

// ---- verilog/dcec_enable_ctrl.sv ----
// Function
// - channel 1 transfer enable: read/write, resets 0, gates selected source
// - channel 1 enable at 0: no transfer, selected source requests ignored
// - channel 1 disabled: selected internal interrupt still reaches CPU
// - channel 1 end irq enable 1 and transfer enable 0: end request
// - channel 1 both enables 1: wait for source request, then transfer
// - channel 1 enable cleared by reset, count done, software zero write
// - channel 1 enable sets only on write 1 after reading it 0
// - channel 0 master enable read/write, resets 0, ANDed with enable
// - NMI mid burst on channel 0 clears master enable, stops, frees bus
// - setting channel 0 master enable again resumes the stopped transfer
// - block mode: NMI leaves channel 0 master enable and transfer alone
// - channel 0 master cleared by reset, burst NMI, software zero write
// - channel 0 master enable sets only on write 1 after reading 0
// - channel 1 runs only with master enable and transfer enable both 1
// - channel 0 both enables 1: wait for source request, then transfer
//
// The implementer's own choices: the register addresses and the Wishbone register port.
`timescale 1ns/100ps
`default_nettype none
module dcec_enable_ctrl (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [dcec_pkg::DCEC_AW-1:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [dcec_pkg::DCEC_DW-1:0] wb_dat_i,
   output logic [dcec_pkg::DCEC_DW-1:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic [dcec_pkg::DCEC_NSRC-1:0] srcReq,
   input wire dcec_pkg::dcec_eng_t engStat,
   input wire logic nmiPin,
   output logic ch0Run,
   output logic ch1Run,
   output logic ch0Req,
   output logic ch1Req,
   output logic ch0BusRelease,
   output logic [dcec_pkg::DCEC_NSRC-1:0] cpuIrqFwd,
   output logic ch1EndReq,
   output logic irq
);
   import dcec_pkg::*;

   dcec_ctrl_t ctrl_q;
   logic [DCEC_SELW-1:0] ch0Sel_q, ch1Sel_q;
   logic [DCEC_STW-1:0] stat_q, mask_q;
   logic [DCEC_STW-1:0] statSet;
   logic ack_q;
   logic [DCEC_DW-1:0] rdat_q;
   logic nmiMeta_q, nmiSync_q, nmiPrev_q;
   logic nmiEdge;
   logic ch1XferPrev_q;
   logic held_q;
   logic seen0Xfer_q, seen0Master_q, seen1Xfer_q, seen1Master_q;
   logic busReq, wrAct, rdAct;
   logic wrCtrl, wrSrc, wrStat, wrMask;
   logic burstNmi;
   logic [DCEC_NSRC-1:0] consumed;

   assign busReq = wb_cyc_i & wb_stb_i;
   // access completes at the edge that samples ack high
   assign wrAct = busReq & ack_q & wb_we_i;
   assign rdAct = busReq & ack_q & ~wb_we_i;
   assign wrCtrl = wrAct & (wb_adr_i == DCEC_CTRL_OFF);
   assign wrSrc = wrAct & (wb_adr_i == DCEC_SRC_OFF) & wb_sel_i[0];
   assign wrStat = wrAct & (wb_adr_i == DCEC_STAT_OFF) & wb_sel_i[0];
   assign wrMask = wrAct & (wb_adr_i == DCEC_MASK_OFF) & wb_sel_i[0];

   // bus slave: one wait state, ack for one cycle
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ack_q <= 1'b0;
      end else begin
         ack_q <= busReq & ~ack_q;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rdat_q <= '0;
      end else if (busReq & ~ack_q) begin
         rdat_q <= '0;
         case (wb_adr_i)
            DCEC_CTRL_OFF: begin
               rdat_q[DCEC_CH1_MASTER_BIT] <= ctrl_q.ch1Master;
               rdat_q[DCEC_CH1_XFER_BIT] <= ctrl_q.ch1Xfer;
               rdat_q[DCEC_CH0_MASTER_BIT] <= ctrl_q.ch0Master;
               rdat_q[DCEC_CH0_XFER_BIT] <= ctrl_q.ch0Xfer;
               rdat_q[DCEC_CH1_END_IE_BIT] <= ctrl_q.ch1EndIe;
               rdat_q[DCEC_CH0_BURST_BIT] <= ctrl_q.ch0Burst;
            end
            DCEC_SRC_OFF: begin
               rdat_q[DCEC_CH0_SEL_LSB +: DCEC_SELW] <= ch0Sel_q;
               rdat_q[DCEC_CH1_SEL_LSB +: DCEC_SELW] <= ch1Sel_q;
            end
            DCEC_STAT_OFF: rdat_q[DCEC_STW-1:0] <= stat_q;
            DCEC_MASK_OFF: rdat_q[DCEC_STW-1:0] <= mask_q;
            DCEC_STATE_OFF: begin
               rdat_q[DCEC_SS_CH0_RUN] <= ch0Run;
               rdat_q[DCEC_SS_CH1_RUN] <= ch1Run;
               rdat_q[DCEC_SS_CH0_HELD] <= held_q;
               rdat_q[DCEC_SS_CH1_END_REQ] <= ch1EndReq;
            end
            default: rdat_q <= '0;
         endcase
      end
   end

   assign wb_dat_o = rdat_q;
   assign wb_ack_o = ack_q;

   // nmi pin synchroniser and rising edge
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         nmiMeta_q <= 1'b0;
         nmiSync_q <= 1'b0;
         nmiPrev_q <= 1'b0;
      end else begin
         nmiMeta_q <= nmiPin;
         nmiSync_q <= nmiMeta_q;
         nmiPrev_q <= nmiSync_q;
      end
   end

   assign nmiEdge = nmiSync_q & ~nmiPrev_q;
   // block mode (ch0Burst 0) never takes this path
   assign burstNmi = nmiEdge & ctrl_q.ch0Burst & engStat.ch0BurstBusy;

   // read-as-zero tracking for the guarded set
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         seen0Xfer_q <= 1'b0;
         seen0Master_q <= 1'b0;
         seen1Xfer_q <= 1'b0;
         seen1Master_q <= 1'b0;
      end else if (rdAct & (wb_adr_i == DCEC_CTRL_OFF)) begin
         seen0Xfer_q <= ~ctrl_q.ch0Xfer;
         seen0Master_q <= ~ctrl_q.ch0Master;
         seen1Xfer_q <= ~ctrl_q.ch1Xfer;
         seen1Master_q <= ~ctrl_q.ch1Master;
      end else if (wrCtrl & wb_sel_i[0]) begin
         seen0Xfer_q <= 1'b0;
         seen0Master_q <= 1'b0;
         seen1Xfer_q <= 1'b0;
         seen1Master_q <= 1'b0;
      end
   end

   // control bits; hardware clears beat software sets
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ctrl_q <= DCEC_CTRL_RST;
      end else begin
         if (wrCtrl & wb_sel_i[0]) begin
            ctrl_q.ch1EndIe <= wb_dat_i[DCEC_CH1_END_IE_BIT];
            if (!wb_dat_i[DCEC_CH1_XFER_BIT]) begin
               ctrl_q.ch1Xfer <= 1'b0;
            end else if (seen1Xfer_q) begin
               ctrl_q.ch1Xfer <= 1'b1;
            end
            if (!wb_dat_i[DCEC_CH0_XFER_BIT]) begin
               ctrl_q.ch0Xfer <= 1'b0;
            end else if (seen0Xfer_q) begin
               ctrl_q.ch0Xfer <= 1'b1;
            end
            if (!wb_dat_i[DCEC_CH0_MASTER_BIT]) begin
               ctrl_q.ch0Master <= 1'b0;
            end else if (seen0Master_q) begin
               ctrl_q.ch0Master <= 1'b1;
            end
            if (!wb_dat_i[DCEC_CH1_MASTER_BIT]) begin
               ctrl_q.ch1Master <= 1'b0;
            end else if (seen1Master_q) begin
               ctrl_q.ch1Master <= 1'b1;
            end
         end
         if (wrCtrl & wb_sel_i[1]) begin
            ctrl_q.ch0Burst <= wb_dat_i[DCEC_CH0_BURST_BIT];
         end
         if (engStat.ch1Done) begin
            ctrl_q.ch1Xfer <= 1'b0;
         end
         if (engStat.ch0Done) begin
            ctrl_q.ch0Xfer <= 1'b0;
         end
         if (burstNmi) begin
            ctrl_q.ch0Master <= 1'b0;
         end
      end
   end

   // suspended burst remembered until master enable returns or transfer enable clears
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         held_q <= 1'b0;
      end else if (burstNmi) begin
         held_q <= 1'b1;
      end else if (ctrl_q.ch0Master | ~ctrl_q.ch0Xfer) begin
         held_q <= 1'b0;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ch0Sel_q <= DCEC_SEL_RST;
         ch1Sel_q <= DCEC_SEL_RST;
      end else if (wrSrc) begin
         ch0Sel_q <= wb_dat_i[DCEC_CH0_SEL_LSB +: DCEC_SELW];
         ch1Sel_q <= wb_dat_i[DCEC_CH1_SEL_LSB +: DCEC_SELW];
      end
   end

   // run enables and gated requests
   assign ch0Run = ctrl_q.ch0Xfer & ctrl_q.ch0Master;
   assign ch1Run = ctrl_q.ch1Xfer & ctrl_q.ch1Master;
   // engine keeps its counters, so a renewed ch0Run resumes in place
   assign ch0Req = ch0Run & srcReq[ch0Sel_q];
   assign ch1Req = ch1Run & srcReq[ch1Sel_q];
   // bus returns to the channel in the cycle master enable is set again
   assign ch0BusRelease = held_q & ~ctrl_q.ch0Master;
   assign ch1EndReq = ctrl_q.ch1EndIe & ~ctrl_q.ch1Xfer;

   // selected source is taken by an enabled channel, others pass to cpu
   generate
      for (genvar i = 0; i < DCEC_NSRC; i++) begin : g_fwd
         assign consumed[i] = (ctrl_q.ch0Xfer & (ch0Sel_q == DCEC_SELW'(i)))
            | (ctrl_q.ch1Xfer & (ch1Sel_q == DCEC_SELW'(i)));
         assign cpuIrqFwd[i] = srcReq[i] & ~consumed[i];
      end
   endgenerate

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ch1XferPrev_q <= 1'b0;
      end else begin
         ch1XferPrev_q <= ctrl_q.ch1Xfer;
      end
   end

   always_comb begin
      statSet = '0;
      statSet[DCEC_ST_CH1_END] = ch1XferPrev_q & ~ctrl_q.ch1Xfer
         & ctrl_q.ch1EndIe;
      statSet[DCEC_ST_CH0_BREAK] = burstNmi;
      statSet[DCEC_ST_CH0_DONE] = engStat.ch0Done;
      statSet[DCEC_ST_CH1_DONE] = engStat.ch1Done;
   end

   // sticky status, write one to clear, set wins
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         stat_q <= DCEC_STAT_RST;
      end else if (wrStat) begin
         stat_q <= (stat_q & ~wb_dat_i[DCEC_STW-1:0]) | statSet;
      end else begin
         stat_q <= stat_q | statSet;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         mask_q <= DCEC_MASK_RST;
      end else if (wrMask) begin
         mask_q <= wb_dat_i[DCEC_STW-1:0];
      end
   end

   assign irq = |(stat_q & mask_q);
endmodule
`default_nettype wire

// ---- dv/dcec_src_model.sv ----
`timescale 1ns/100ps
`default_nettype none
// interrupt sources and transfer engine beside the block
module dcec_src_model (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic ch0Run,
   input wire logic [1:0] doneCmd,
   input wire logic [15:0] srcCmd,
   output var logic [15:0] srcReq,
   output var dcec_pkg::dcec_eng_t engStat
);
   import dcec_pkg::*;
   // burst engine stays busy while channel 0 runs
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         srcReq <= '0;
         engStat <= '0;
      end else begin
         srcReq <= srcCmd;
         engStat <= {doneCmd, ch0Run};
      end
   end
endmodule
`default_nettype wire

// ---- dv/dcec_enable_ctrl_checker.sv ----
`timescale 1ns/100ps
`default_nettype none
module dcec_enable_ctrl_checker (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [dcec_pkg::DCEC_AW-1:0] wb_adr_i,
   input wire logic [dcec_pkg::DCEC_DW-1:0] wb_dat_o,
   input wire logic wb_ack_o,
   input wire logic [dcec_pkg::DCEC_NSRC-1:0] srcReq,
   input wire dcec_pkg::dcec_eng_t engStat,
   input wire logic ch0Run,
   input wire logic ch1Run,
   input wire logic ch0Req,
   input wire logic ch1Req,
   input wire logic ch0BusRelease,
   input wire logic [dcec_pkg::DCEC_NSRC-1:0] cpuIrqFwd
);
   import dcec_pkg::*;
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   a_ack_wait: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o
      |=> wb_ack_o) else $error("ack late");
   a_ack_once: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack too long");
   a_req0_gate: assert property (ch0Req |-> ch0Run)
      else $error("ch0 request while disabled");
   a_req1_gate: assert property (ch1Req |-> ch1Run)
      else $error("ch1 request while disabled");
   a_req1_src: assert property (ch1Req |-> |srcReq)
      else $error("ch1 request without source");
   a_fwd_src: assert property ((cpuIrqFwd & ~srcReq) == '0)
      else $error("forwarded absent request");
   a_done1_clr: assert property (engStat.ch1Done |=> !ch1Run)
      else $error("ch1 runs after done");
   a_done0_clr: assert property (engStat.ch0Done |=> !ch0Run)
      else $error("ch0 runs after done");
   a_rel_stop: assert property (ch0BusRelease |-> !ch0Run)
      else $error("ch0 runs with bus released");
   a_set1_write: assert property ($rose(ch1Run) |->
      $past(wb_ack_o && wb_we_i))
      else $error("ch1 enabled without write");
   a_set0_write: assert property ($rose(ch0Run) |->
      $past(wb_ack_o && wb_we_i))
      else $error("ch0 enabled without write");
   a_unmap_zero: assert property (wb_ack_o && !wb_we_i &&
      wb_adr_i > 5'h10 |-> wb_dat_o == '0)
      else $error("unmapped read not zero");
endmodule
bind dcec_enable_ctrl dcec_enable_ctrl_checker u_chk (.*);
`default_nettype wire

// ---- dv/dcec_enable_ctrl_tb.sv ----
`timescale 1ns/100ps
`default_nettype none
module dcec_enable_ctrl_tb;
   import dcec_pkg::*;
   logic clk = 0, rst_n = 0, cyc = 0, stb = 0, we = 0, nmi = 0;
   logic [DCEC_AW-1:0] adr = '0;
   logic [3:0] sel = 4'h3;
   logic [31:0] dat = '0, rdo, got;
   logic ack, r0, r1, q0, q1, rel, endReq, irq;
   logic [15:0] srcCmd = '0, srcReq, fwd;
   logic [1:0] doneCmd = '0;
   dcec_eng_t eng;
   int errCount = 0, samplesChecked = 0, cycles = 0;
   always #50 clk = ~clk;
   dcec_src_model src (.clk, .rst_n, .ch0Run(r0), .doneCmd, .srcCmd,
      .srcReq, .engStat(eng));
   dcec_enable_ctrl dut (.clk, .rst_n, .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat),
      .wb_dat_o(rdo), .wb_ack_o(ack), .srcReq, .engStat(eng),
      .nmiPin(nmi), .ch0Run(r0), .ch1Run(r1), .ch0Req(q0), .ch1Req(q1),
      .ch0BusRelease(rel), .cpuIrqFwd(fwd), .ch1EndReq(endReq), .irq);
   task automatic tallyAndFinish;
      if (errCount == 0 && samplesChecked > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   always @(posedge clk) begin
      cycles++;
      if (cycles == 5000) begin
         errCount++;
         tallyAndFinish;
      end
   end
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      samplesChecked++;
      if (g !== e) begin
         errCount++;
         $display("[ERR] %0t got %h exp %h", $time, g, e);
      end
   endtask
   task automatic bus(input logic w, input logic [4:0] a,
      input logic [31:0] d);
      @(posedge clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      dat <= d;
      do @(posedge clk); while (ack !== 1'b1);
      got = rdo;
      cyc <= 1'b0;
      stb <= 1'b0;
      @(posedge clk);
   endtask
   task automatic rc(input logic [4:0] a, input logic [31:0] e);
      bus(1'b0, a, '0);
      chk(got, e);
   endtask
   // one-cycle done pulse, two-cycle nmi pulse, then settle
   task automatic kick(input logic [1:0] d, input logic n);
      @(posedge clk);
      doneCmd <= d;
      nmi <= n;
      @(posedge clk);
      doneCmd <= 2'b00;
      @(posedge clk);
      nmi <= 1'b0;
      repeat (8) @(negedge clk);
   endtask
   task automatic t_guard;
      bus(1'b1, DCEC_CTRL_OFF, 32'hf0);
      rc(DCEC_CTRL_OFF, 32'h0);
      bus(1'b1, DCEC_CTRL_OFF, 32'hf0);
      rc(DCEC_CTRL_OFF, 32'hf0);
      chk({r0, r1}, 2'h3);
   endtask
   task automatic t_source;
      bus(1'b1, DCEC_SRC_OFF, 32'h21);
      srcCmd <= 16'h0006;
      repeat (2) @(negedge clk);
      chk({q0, q1}, 2'h3);
      chk(fwd, 16'h0);
      bus(1'b1, DCEC_CTRL_OFF, 32'hb0);
      chk({r1, q1}, 2'h0);
      chk(fwd, 16'h0004);
   endtask
   task automatic t_end;
      bus(1'b1, DCEC_MASK_OFF, 32'h1);
      rc(DCEC_CTRL_OFF, 32'hb0);
      bus(1'b1, DCEC_CTRL_OFF, 32'hf4);
      chk({r1, endReq, irq}, 3'h4);
      kick(2'b01, 1'b0);
      chk(r1, 1'b0);
      chk(endReq, 1'b1);
      rc(DCEC_STAT_OFF, 32'h9);
      chk(irq, 1'b1);
      bus(1'b1, DCEC_STAT_OFF, 32'h1);
      rc(DCEC_STAT_OFF, 32'h8);
      chk(irq, 1'b0);
   endtask
   task automatic t_burst;
      bus(1'b1, DCEC_CTRL_OFF, 32'h1b4);
      kick(2'b00, 1'b1);
      chk({r0, rel}, 2'h1);
      rc(DCEC_CTRL_OFF, 32'h194);
      bus(1'b1, DCEC_CTRL_OFF, 32'h1b4);
      chk({r0, rel}, 2'h2);
   endtask
   task automatic t_block;
      bus(1'b1, DCEC_CTRL_OFF, 32'hb4);
      kick(2'b00, 1'b1);
      chk({r0, rel}, 2'h2);
      rc(DCEC_CTRL_OFF, 32'hb4);
      rc(5'h14, 32'h0);
      kick(2'b10, 1'b0);
      chk(r0, 1'b0);
   endtask
   initial begin
      repeat (12) @(posedge clk);
      rst_n <= 1'b1;
      t_guard;
      t_source;
      t_end;
      t_burst;
      t_block;
      tallyAndFinish;
   end
endmodule
`default_nettype wire
